// ==== logic/dcx_regs.svh ====
// Purpose: constants for the data counter exchange unit
// Assumes: cycle control codes are five bits wide
// Notes:   codes other than exchange are this block's own picks
`ifndef DCX_REGS_SVH
`define DCX_REGS_SVH
`define DCX_CODE_W        5
`define DCX_ADDR_W        16
`define DCX_CODE_EXCHANGE 5'h1D
`define DCX_CODE_LOAD     5'h0C
`define DCX_CODE_REF      5'h05
`define DCX_CODE_STORE    5'h1F
`define DCX_CODE_OUT_HI   5'h06
`define DCX_CODE_OUT_LO   5'h07
`define DCX_CNT_RESET     16'h0000
`define DCX_SLOT_NS       100
`define DCX_CLK_NS        100
`define DCX_SLOT_CYC      ((`DCX_SLOT_NS + `DCX_CLK_NS - 1) / `DCX_CLK_NS)
`endif

// ==== logic/dcx_pkg.sv ====
// Purpose: types for the data counter exchange unit
// Assumes: nothing beyond the constants header
// Notes:   none
`default_nettype none
package dcx_pkg;
  typedef struct packed {
    logic       exchange;
    logic       load;
    logic       mem_ref;
    logic       out_hi;
    logic       out_lo;
    logic       store;
  } dcx_op_t;
  typedef enum logic [1:0] {
    DCX_IDLE   = 2'b00,
    DCX_DECODE = 2'b01,
    DCX_EXEC   = 2'b10
  } dcx_state_t;
endpackage
`default_nettype wire

// ==== logic/dcx_timing.sv ====
// Purpose: derives memory timing from phase clock and write strobe
// Assumes: phase and write already synchronised to sys_clk
// Notes:   cycle request halves the phase clock except during stores
`timescale 1ns/1ps
`default_nettype none
module dcx_timing
  import dcx_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic phase_rise,
  input  wire logic write_rise,
  input  wire logic store_op,
  output logic      cycle_req,
  output logic      mem_idle,
  output logic      cpu_slot
);
  logic cyc_q;
  logic idle_q;
  logic slot_q;

  // divide-by-two of phase, held still through a store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc_q <= 1'b0;
    end else if (write_rise) begin
      cyc_q <= 1'b0;
    end else if (phase_rise && !store_op) begin
      cyc_q <= ~cyc_q;
    end
  end

  // idle marks the second access period, free for refresh or dma
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_q <= 1'b0;
      slot_q <= 1'b0;
    end else begin
      if (write_rise) begin
        slot_q <= 1'b1;
      end else if (phase_rise && cyc_q) begin
        slot_q <= 1'b0;
      end
      if (phase_rise && cyc_q && !store_op) begin
        idle_q <= ~slot_q;
      end else if (write_rise) begin
        idle_q <= 1'b0;
      end
    end
  end

  assign cycle_req = cyc_q;
  assign mem_idle  = idle_q;
  assign cpu_slot  = slot_q;

  chk_store_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_rise && store_op && !write_rise) |=> $stable(cycle_req))
    else $error("cycle request moved during a store");
  chk_phase_half: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_rise && !store_op && !write_rise) |=> (cycle_req != $past(cycle_req)))
    else $error("cycle request did not toggle on phase");
endmodule // dcx_timing
`default_nettype wire

// ==== logic/dcx_unit.sv ====
// Purpose: primary and auxiliary data counters with exchange
// Assumes: cycle code, phase and write come from the cpu pins
// Notes:   data bus is driven only when this device is selected
`timescale 1ns/1ps
`default_nettype none
`include "dcx_regs.svh"
////////////////////////////////////////////////////////////////////////
// How it works
// - exchange code swaps primary and auxiliary counters
// - companion ignores exchange; only ours swaps
// - selected device drives counter byte onto bus
// - memory reference adds one to primary counter
// - selection depends only on own address window
// - load writes primary, auxiliary left unchanged
// - auxiliary changes only through the exchange
// - device derives memory timing from phase, write
// - drive bus only when drive select high
// - cycle request halves phase except on store
module dcx_unit
  import dcx_pkg::*;
#(
  parameter logic [15:0] SPACE_LO = 16'h0400,
  parameter logic [15:0] SPACE_HI = 16'hFFFF,
  parameter int          ADDR_W   = `DCX_ADDR_W
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        phase_pin,
  input  wire logic        write_pin,
  input  wire logic [4:0]  cycle_control_code,
  input  wire logic        mem_ref_pin,
  input  wire logic        register_drive_select,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  output logic      [15:0] addr_out,
  output logic             selected,
  output logic             cycle_req,
  output logic             mem_idle,
  output logic             cpu_slot
);
  if (ADDR_W != 16) begin : g_bad_width
    $error("address width must be 16");
  end
  if (SPACE_LO > SPACE_HI) begin : g_bad_window
    $error("address window inverted");
  end

  ////////////////////////////////////////////////////////////////////
  logic [1:0]       ph_s;
  logic [1:0]       wr_s;
  logic [1:0]       dr_s;
  logic [1:0]       mr_s;
  logic [4:0]       code_s0;
  logic [4:0]       code_s1;
  logic [7:0]       din_s0;
  logic [7:0]       din_s1;
  logic             ph_last_q;
  logic             wr_last_q;
  logic             phase_rise;
  logic             write_rise;
  logic [15:0]      primary_data_counter_q;
  logic [15:0]      auxiliary_data_counter_q;
  logic [7:0]       load_hi_q;
  logic [7:0]       dout_q;
  logic             oe_n_q;
  dcx_op_t          op;
  dcx_state_t       state_q;

  // two-stage capture of every cpu pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_s    <= 2'h0;
      wr_s    <= 2'h0;
      dr_s    <= 2'h3;
      mr_s    <= 2'h0;
      code_s0 <= 5'h00;
      code_s1 <= 5'h00;
      din_s0  <= 8'h00;
      din_s1  <= 8'h00;
    end else begin
      ph_s    <= {ph_s[0], phase_pin};
      wr_s    <= {wr_s[0], write_pin};
      dr_s    <= {dr_s[0], register_drive_select};
      mr_s    <= {mr_s[0], mem_ref_pin};
      code_s0 <= cycle_control_code;
      code_s1 <= code_s0;
      din_s0  <= data_in;
      din_s1  <= din_s0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_last_q <= 1'b0;
      wr_last_q <= 1'b0;
    end else begin
      ph_last_q <= ph_s[1];
      wr_last_q <= wr_s[1];
    end
  end
  assign phase_rise = ph_s[1] & ~ph_last_q;
  assign write_rise = wr_s[1] & ~wr_last_q;

  function automatic dcx_op_t decode(input logic [4:0] c, input logic mr);
    dcx_op_t o;
    o          = '0;
    o.exchange = (c == `DCX_CODE_EXCHANGE);
    o.load     = (c == `DCX_CODE_LOAD);
    o.out_hi   = (c == `DCX_CODE_OUT_HI);
    o.out_lo   = (c == `DCX_CODE_OUT_LO);
    o.store    = (c == `DCX_CODE_STORE);
    o.mem_ref  = mr;
    return o;
  endfunction

  function automatic logic in_space(input logic [15:0] a);
    return (a >= SPACE_LO) && (a <= SPACE_HI);
  endfunction

  assign op = decode(code_s1, mr_s[1]);

  ////////////////////////////////////////////////////////////////////
  // one action per instruction, taken in the exec state two clocks after the write strobe rise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= DCX_IDLE;
    end else begin
      case (state_q)
        DCX_IDLE:   state_q <= write_rise ? DCX_DECODE : DCX_IDLE;
        DCX_DECODE: state_q <= DCX_EXEC;
        DCX_EXEC:   state_q <= DCX_IDLE;
        default:    state_q <= DCX_IDLE;
      endcase
    end
  end

  // load arrives high byte then low byte on consecutive instructions
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      load_hi_q <= 8'h00;
    end else if (state_q == DCX_EXEC && op.out_hi) begin
      load_hi_q <= din_s1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      primary_data_counter_q <= `DCX_CNT_RESET;
    end else if (state_q == DCX_EXEC) begin
      if (op.exchange) begin
        primary_data_counter_q <= auxiliary_data_counter_q;
      end else if (op.load) begin
        primary_data_counter_q <= {load_hi_q, din_s1};
      end else if (op.mem_ref) begin
        primary_data_counter_q <= primary_data_counter_q + 16'h0001;
      end
    end
  end

  // no reset value is promised to software before the first swap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      auxiliary_data_counter_q <= `DCX_CNT_RESET;
    end else if (state_q == DCX_EXEC && op.exchange) begin
      auxiliary_data_counter_q <= primary_data_counter_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // selection ignores other devices; contention is software's problem
  assign selected = in_space(primary_data_counter_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dout_q <= 8'h00;
      oe_n_q <= 1'b1;
    end else if (state_q == DCX_DECODE && (op.out_hi || op.out_lo)
                 && selected && dr_s[1]) begin
      dout_q <= op.out_hi ? primary_data_counter_q[15:8]
                          : primary_data_counter_q[7:0];
      oe_n_q <= 1'b0;
    end else if (state_q == DCX_IDLE) begin
      oe_n_q <= 1'b1;
    end
  end

  assign data_out  = dout_q;
  assign data_oe_n = oe_n_q;
  assign addr_out  = primary_data_counter_q;

  dcx_timing u_timing (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .phase_rise (phase_rise),
    .write_rise (write_rise),
    .store_op   (op.store),
    .cycle_req  (cycle_req),
    .mem_idle   (mem_idle),
    .cpu_slot   (cpu_slot)
  );

  ////////////////////////////////////////////////////////////////////
  sequence s_exec_swap;
    state_q == DCX_EXEC && op.exchange;
  endsequence
  chk_swap_both: assert property (@(posedge sys_clk) disable iff (rst)
    s_exec_swap |=> (primary_data_counter_q == $past(auxiliary_data_counter_q)
                     && auxiliary_data_counter_q == $past(primary_data_counter_q)))
    else $error("exchange did not swap counters");
  chk_aux_only_swap: assert property (@(posedge sys_clk) disable iff (rst)
    !(state_q == DCX_EXEC && op.exchange) |=> $stable(auxiliary_data_counter_q))
    else $error("auxiliary changed without exchange");
  chk_load_primary: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == DCX_EXEC && op.load && !op.exchange)
      |=> primary_data_counter_q == {$past(load_hi_q), $past(din_s1)})
    else $error("load value missing");
  chk_incr_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == DCX_EXEC && op.mem_ref && !op.load && !op.exchange)
      |=> primary_data_counter_q == 16'($past(primary_data_counter_q) + 16'h0001))
    else $error("increment wrong");
  chk_sel_window: assert property (@(posedge sys_clk) disable iff (rst)
    selected == (primary_data_counter_q >= SPACE_LO && primary_data_counter_q <= SPACE_HI))
    else $error("selection wrong");
  chk_drive_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == DCX_DECODE && !dr_s[1] && oe_n_q) |=> data_oe_n)
    else $error("bus driven with drive select low");
  chk_drive_sel: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == DCX_DECODE && op.out_lo && selected && dr_s[1])
      |=> (!data_oe_n && data_out == $past(primary_data_counter_q[7:0])))
    else $error("counter byte not driven");
  chk_oe_release: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == DCX_IDLE) |=> data_oe_n)
    else $error("bus left driven");
endmodule // dcx_unit
`default_nettype wire

// ==== testbench/dcx_cpu_model.sv ====
// Purpose: cpu side: phase clock, write strobe, cycle codes, bus data
// Assumes: unit samples code and write through two sync stages
// Notes:   released bus data turns to the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module dcx_cpu_model
  import dcx_pkg::*;
(
  input  wire logic       sys_clk,
  output wire logic       phase_pin,
  output var  logic       write_pin,
  output var  logic [4:0] cycle_control_code,
  output var  logic       mem_ref_pin,
  output var  logic [7:0] data_in
);
  logic [1:0] ph_div = 2'h0;
  // phase runs free, four system clocks a period
  always @(negedge sys_clk) ph_div <= ph_div + 2'h1;
  assign phase_pin = ph_div[1];
  initial begin
    write_pin = 1'b0;
    cycle_control_code = 5'h00;
    mem_ref_pin = 1'b0;
    data_in = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // code settles a cycle ahead of the strobe and holds all instruction
  task automatic issue(input logic [4:0] code, input logic mref, input logic [7:0] din);
    @(negedge sys_clk);
    cycle_control_code = code;
    mem_ref_pin = mref;
    data_in = din;
    @(negedge sys_clk);
    write_pin = 1'b1;
    repeat (8) @(negedge sys_clk);
    write_pin = 1'b0;
    mem_ref_pin = 1'b0;
    data_in = ~din;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule // dcx_cpu_model
`default_nettype wire

// ==== testbench/data_counter_exchange_unit_tb.sv ====
// Purpose: self-checking bench for the data counter exchange unit
// Assumes: default address window 0x0400 to 0xFFFF
// Notes:   auxiliary counter starts at zero after reset
`timescale 1ns/1ps
`default_nettype none
`include "dcx_regs.svh"
module data_counter_exchange_unit_tb;
  import dcx_pkg::*;
  logic sys_clk, rst, phase_pin, write_pin, mem_ref_pin, drive_sel;
  logic       data_oe_n, selected, cycle_req, drove, mem_idle, cpu_slot;
  logic [4:0] code;
  logic [7:0] data_in, data_out, drv_byte;
  logic [15:0] addr_out;
  int errors = 0, num_checks = 0, cyc = 0;
  dcx_cpu_model cpu_u (.sys_clk(sys_clk), .phase_pin(phase_pin), .write_pin(write_pin),
    .cycle_control_code(code), .mem_ref_pin(mem_ref_pin), .data_in(data_in));
  dcx_unit dut_u (.sys_clk(sys_clk), .rst(rst), .phase_pin(phase_pin),
    .write_pin(write_pin), .cycle_control_code(code), .mem_ref_pin(mem_ref_pin),
    .register_drive_select(drive_sel), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .addr_out(addr_out), .selected(selected),
    .cycle_req(cycle_req), .mem_idle(mem_idle), .cpu_slot(cpu_slot));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // remembers whether and what the unit put on the bus
  always @(posedge sys_clk) if (data_oe_n === 1'b0) begin
    drove <= 1'b1;
    drv_byte <= data_out;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic load(input logic [15:0] v);
    cpu_u.issue(`DCX_CODE_OUT_HI, 1'b0, v[15:8]);
    cpu_u.issue(`DCX_CODE_LOAD, 1'b0, v[7:0]);
  endtask
  task automatic drive_try(input logic [4:0] c, input logic d, input logic [7:0] exp);
    drove = 1'b0;
    cpu_u.issue(c, 1'b0, 8'hA5);
    check(drove, d);
    if (d) check(drv_byte, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_exchange();
    load(16'h0500);
    check(addr_out, 16'h0500);
    cpu_u.issue(`DCX_CODE_EXCHANGE, 1'b0, 8'h00);
    check(addr_out, 16'h0000);
    load(16'h0700);
    check(addr_out, 16'h0700);
    cpu_u.issue(`DCX_CODE_EXCHANGE, 1'b0, 8'h00);
    check(addr_out, 16'h0500);
    cpu_u.issue(`DCX_CODE_EXCHANGE, 1'b0, 8'h00);
    check(addr_out, 16'h0700);
  endtask
  task automatic t_increment();
    load(16'h05FE);
    repeat (2) cpu_u.issue(`DCX_CODE_REF, 1'b1, 8'h00);
    check(addr_out, 16'h0600);
    load(16'hFFFF);
    check(selected, 1'b1);
    cpu_u.issue(`DCX_CODE_REF, 1'b1, 8'h00);
    check(addr_out, 16'h0000);
    check(selected, 1'b0);
    load(16'h03FF);
    check(selected, 1'b0);
  endtask
  task automatic t_drive();
    load(16'h0512);
    drive_try(`DCX_CODE_OUT_LO, 1'b1, 8'h12);
    drive_try(`DCX_CODE_OUT_HI, 1'b1, 8'h05);
    drive_sel = 1'b0;
    drive_try(`DCX_CODE_OUT_LO, 1'b0, 8'h00);
    drive_sel = 1'b1;
    load(16'h0300);
    drive_try(`DCX_CODE_OUT_LO, 1'b0, 8'h00);
  endtask
  // counts phase rises and cycle request toggles over 64 clocks
  task automatic watch_phase(output int rises, output int toggles);
    logic ph, cr;
    rises = 0;
    toggles = 0;
    @(negedge sys_clk);
    ph = phase_pin;
    cr = cycle_req;
    repeat (64) begin
      @(negedge sys_clk);
      if (phase_pin && !ph) rises++;
      if (cycle_req !== cr) toggles++;
      ph = phase_pin;
      cr = cycle_req;
    end
  endtask
  task automatic t_cycle_req();
    int rises, toggles;
    watch_phase(rises, toggles);
    check(16'(rises), 16'h0010);
    // sync delay may shift one toggle across the window edge
    check(16'(toggles >= rises - 1 && toggles <= rises + 1), 16'h0001);
    check(mem_idle, 1'b1);
    check(cpu_slot, 1'b0);
    // a store leaves no free access period and holds cycle request
    cpu_u.issue(`DCX_CODE_STORE, 1'b0, 8'h00);
    watch_phase(rises, toggles);
    check(16'(toggles), 16'h0000);
    check(mem_idle, 1'b0);
    check(cpu_slot, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    drive_sel = 1'b1;
    drove = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(addr_out, 16'h0000);
    check(data_oe_n, 1'b1);
    t_exchange();
    t_increment();
    t_drive();
    t_cycle_req();
    conclude();
  end
endmodule // data_counter_exchange_unit_tb
`default_nettype wire
